// >>> core/ofd_decoder.sv
// Contract
// [RL1] Access field 0 uses fixed access region; 1 takes bank from bank select register.
// [RL2] Three-bit bit field picks bit zero to seven of the addressed byte.
// [RL3] Destination field 0 sends result to accumulator, 1 to the file register.
// [RL4] Short address is an eight-bit register address or two-bit pointer selector.
// [RL5] Register moves carry twelve-bit source and destination addresses.
// [RL6] Literal is extracted as eight, twelve or twenty bits by format.
// [RL7] Table ops pick hold, post-increment, post-decrement or pre-increment pointer mode.
// [RL8] Branch field is signed displacement when relative, direct address otherwise.
// [RL9] Fast bit 1 saves shadows on call, restores on return; 0 leaves them.
// [RL10] Table pointer is 21 bits; transfers pass through an eight-bit latch.
// [RL11] Don't-care instruction bits never affect decoding or execution.
// [RL12] Indexed forms add seven-bit source and destination offsets to a pointer; the code adds the destination offset only when first-word bit 7 is set.
// [RL13] Five status flags kept: carry, half carry, zero, signed wrap, negative.
// [RL14] A lone word with top four bits all ones executes as no-operation.
// [RL15] All operand fields appear in the same cycle the word is decoded.
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module ofd_decoder (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // AXI4-Lite slave.
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Instruction words from the fetch unit.
  input wire logic [15:0] i_instr,
  input wire logic i_instr_valid,
  // Datapath inputs.
  input wire logic [4:0] i_alu_flags,
  input wire logic [7:0] i_working_accumulator,
  input wire logic [7:0] i_tbl_rdata,
  // Decoded operand fields.
  output ofd_pkg::ofd_class_t o_class,
  output logic o_nop,
  output logic o_second_word,
  output logic [11:0] o_file_addr,
  output logic [2:0] o_bit_sel,
  output logic [7:0] o_bit_mask,
  output logic o_dest_file,
  output logic [1:0] o_ptr_sel,
  output logic [11:0] o_src_addr,
  output logic [11:0] o_dst_addr,
  output logic [19:0] o_literal,
  output ofd_pkg::ofd_lit_t o_lit_kind,
  output logic o_branch_rel,
  output logic [20:0] o_branch_disp,
  output logic [19:0] o_branch_target,
  output logic [4:0] o_flag_mask,
  // Flags, table and shadow side.
  output logic [4:0] o_flags,
  output ofd_pkg::ofd_tbl_mode_t o_tbl_mode,
  output logic o_tbl_rd,
  output logic o_tbl_wr,
  output logic [20:0] o_tbl_addr,
  output logic [7:0] o_tbl_wdata,
  output logic o_shadow_save,
  output logic o_shadow_restore,
  output logic [7:0] o_shadow_accumulator
);
  logic [3:0] bank, next_bank, sh_bank, next_sh_bank;
  logic [11:0] ptr [3];
  logic [11:0] next_ptr [3];
  logic [20:0] tbl_ptr, next_tbl_ptr, tbl_next;
  logic [7:0] tbl_latch, next_tbl_latch, sh_acc, next_sh_acc;
  logic [4:0] flags, next_flags, sh_flags, next_sh_flags;
  logic pend, next_pend;
  logic [15:0] first, next_first, last, next_last;
  logic aw_full, next_aw_full, w_full, next_w_full, bvalid, next_bvalid, rvalid, next_rvalid;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data, rdata, next_rdata, bus_wval, rd_val;
  logic [3:0] w_strb, next_w_strb;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic bus_we, rd_hit, wr_hit, ex, lfsr_we, bank_lit_we, acc_bit;
  logic [2:0] ptr_bus_we;
  logic [7:0] f8;

  // Access field 0 folds the byte into the split fixed region, 1 uses the bank.
  function automatic logic [11:0] ofd_bank_addr(input logic a, input logic [7:0] f,
                                                input logic [3:0] b);
    if (a) begin
      return {b, f}; // [RL1]
    end
    return (f < ofd_pkg::ACCESS_SPLIT) ? {4'h0, f} : {ofd_pkg::ACCESS_HI_BANK, f}; // [RL1]
  endfunction : ofd_bank_addr

  // Flags that a single-word operation may touch, keyed by its opcode bits only.
  function automatic logic [4:0] ofd_flag_mask(input logic [15:0] w);
    casez (w[15:8])
      8'b0010_0???, 8'b0000_01??, 8'b0010_10??, 8'b0101_01??, 8'b0101_1???,
      8'b0110_110?, 8'b0000_1111, 8'b0000_1000: return ofd_pkg::MASK_ALL; // [RL13]
      8'b0001_????, 8'b0101_00??, 8'b0100_0???, 8'b0000_1001, 8'b0000_1010,
      8'b0000_1011: return ofd_pkg::MASK_ZN; // [RL13]
      8'b0011_0???: return ofd_pkg::MASK_CZN; // [RL13]
      8'b0110_101?: return ofd_pkg::MASK_Z; // [RL13]
      default: return ofd_pkg::MASK_NONE;
    endcase
  endfunction : ofd_flag_mask

  // Table pointer arithmetic.
  ofd_tbl_ptr_unit u_tbl_ptr (
    .i_ptr(tbl_ptr),
    .i_mode(o_tbl_mode),
    .o_addr(o_tbl_addr),
    .o_next(tbl_next)
  );

  // Field decode is combinational on the word now presented, the held first word and the bank and pointer registers.
  always_comb begin
    f8 = i_instr[7:0];
    acc_bit = i_instr[ofd_pkg::POS_ACC];
    o_class = ofd_pkg::OFD_CL_CTRL;
    o_nop = 1'b0;
    o_second_word = pend;
    o_file_addr = ofd_bank_addr(acc_bit, f8, bank); // [RL15]
    o_bit_sel = i_instr[11:9]; // [RL2]
    o_bit_mask = 8'h01 << i_instr[11:9]; // [RL2]
    o_dest_file = i_instr[ofd_pkg::POS_DEST]; // [RL3]
    o_ptr_sel = i_instr[5:4];
    o_src_addr = 12'h000;
    o_dst_addr = 12'h000;
    o_literal = {12'h000, f8};
    o_lit_kind = ofd_pkg::OFD_LIT_NONE;
    o_branch_rel = 1'b0;
    o_branch_disp = 21'h000000;
    o_branch_target = 20'h00000;
    o_flag_mask = ofd_pkg::MASK_NONE;
    o_tbl_mode = ofd_pkg::ofd_tbl_mode_t'(i_instr[1:0]); // [RL7]
    o_tbl_rd = 1'b0;
    o_tbl_wr = 1'b0;
    o_shadow_save = 1'b0;
    o_shadow_restore = 1'b0;
    lfsr_we = 1'b0;
    bank_lit_we = 1'b0;
    if (pend) begin
      // Second word: fields combine the held first word with this one.
      casez (first)
        16'b1100_????_????_????: begin
          o_class = ofd_pkg::OFD_CL_MOVFF;
          o_src_addr = first[11:0]; // [RL5]
          o_dst_addr = i_instr[11:0]; // [RL5]
        end
        16'b1110_11?1_????_????, 16'b1110_110?_????_????: begin
          o_class = ofd_pkg::OFD_CL_CTRL;
          o_branch_target = {i_instr[11:0], first[7:0]}; // [RL8]
          o_literal = {i_instr[11:0], first[7:0]}; // [RL6]
          o_lit_kind = ofd_pkg::OFD_LIT_20; // [RL6]
          o_shadow_save = (first[11:9] == 3'b110) && first[ofd_pkg::POS_CALL_FAST]; // [RL9]
        end
        16'b1110_1110_00??_????: begin
          o_class = ofd_pkg::OFD_CL_LIT;
          o_ptr_sel = first[5:4]; // [RL4]
          o_literal = {8'h00, first[3:0], i_instr[7:0]}; // [RL6]
          o_lit_kind = ofd_pkg::OFD_LIT_12; // [RL6]
          lfsr_we = 1'b1;
        end
        16'b1110_1011_????_????: begin
          o_class = ofd_pkg::OFD_CL_INDEXED;
          o_src_addr = ptr[2] + {5'h00, first[6:0]}; // [RL12]
          o_dst_addr = first[7] ? ptr[2] + {5'h00, i_instr[6:0]} : i_instr[11:0]; // [RL12]
        end
        default: begin
          o_class = ofd_pkg::OFD_CL_NOP;
          o_nop = 1'b1;
        end
      endcase
    end else begin
      casez (i_instr)
        16'b1111_????_????_????: begin
          o_class = ofd_pkg::OFD_CL_NOP; // [RL14]
          o_nop = 1'b1; // [RL14]
        end
        16'b1100_????_????_????, 16'b1110_11??_????_????, 16'b1110_1011_????_????:
          o_class = ofd_pkg::OFD_CL_FIRST;
        16'b0111_????_????_????, 16'b10??_????_????_????:
          o_class = ofd_pkg::OFD_CL_BIT; // [RL2]
        16'b0000_01??_????_????, 16'b0000_001?_????_????, 16'b0001_????_????_????,
        16'b001?_????_????_????, 16'b010?_????_????_????, 16'b0110_????_????_????: begin
          o_class = ofd_pkg::OFD_CL_BYTE;
          // File-only forms always write back; 0000_001? forms never do; the rest obey the destination field.
          o_dest_file = (i_instr[15:12] == 4'h6) |
                        (i_instr[ofd_pkg::POS_DEST] & (i_instr[15:9] != 7'h01)); // [RL3]
          o_flag_mask = ofd_flag_mask(i_instr);
        end
        16'b0000_1???_????_????: begin
          o_class = ofd_pkg::OFD_CL_LIT;
          o_lit_kind = ofd_pkg::OFD_LIT_8; // [RL6]
          o_flag_mask = ofd_flag_mask(i_instr);
        end
        16'b0000_0001_????_????: begin
          o_class = ofd_pkg::OFD_CL_LIT;
          o_literal = {16'h0000, i_instr[3:0]}; // [RL11]
          o_lit_kind = ofd_pkg::OFD_LIT_8;
          bank_lit_we = 1'b1;
        end
        16'b0000_0000_0001_00??: begin
          o_shadow_restore = i_instr[ofd_pkg::POS_RET_FAST]; // [RL9]
        end
        16'b0000_0000_0000_1???: begin
          o_class = ofd_pkg::OFD_CL_TABLE;
          o_tbl_rd = ~i_instr[2] & i_instr_valid;
          o_tbl_wr = i_instr[2] & i_instr_valid;
        end
        16'b1101_????_????_????: begin
          o_class = ofd_pkg::OFD_CL_BRANCH;
          o_branch_rel = 1'b1; // [RL8]
          o_branch_disp = {{10{i_instr[10]}}, i_instr[10:0]}; // [RL8]
        end
        16'b1110_0???_????_????: begin
          o_class = ofd_pkg::OFD_CL_BRANCH;
          o_branch_rel = 1'b1; // [RL8]
          o_branch_disp = {{13{i_instr[7]}}, i_instr[7:0]}; // [RL8]
        end
        default: o_class = ofd_pkg::OFD_CL_CTRL;
      endcase
    end
    o_shadow_save = o_shadow_save & i_instr_valid;
    o_shadow_restore = o_shadow_restore & i_instr_valid;
  end

  assign ex = i_instr_valid;
  assign o_flags = flags;
  assign o_tbl_wdata = tbl_latch; // [RL10]
  assign o_awready = ~aw_full;
  assign o_wready = ~w_full;
  assign o_bvalid = bvalid;
  assign o_bresp = bresp;
  assign o_arready = ~rvalid;
  assign o_rvalid = rvalid;
  assign o_rdata = rdata;
  assign o_rresp = rresp;
  assign o_shadow_accumulator = sh_acc;

  // Bus write data merged under byte strobes against the addressed register.
  always_comb begin
    rd_val = 32'h00000000;
    rd_hit = 1'b1;
    case (i_araddr)
      ofd_pkg::OFS_BANK: rd_val = {28'h0000000, bank};
      ofd_pkg::OFS_PTR0: rd_val = {20'h00000, ptr[0]};
      ofd_pkg::OFS_PTR0 + 8'h04: rd_val = {20'h00000, ptr[1]};
      ofd_pkg::OFS_PTR2: rd_val = {20'h00000, ptr[2]};
      ofd_pkg::OFS_TBL_PTR: rd_val = {11'h000, tbl_ptr};
      ofd_pkg::OFS_TBL_LATCH: rd_val = {24'h000000, tbl_latch};
      ofd_pkg::OFS_FLAGS: rd_val = {27'h0000000, flags};
      ofd_pkg::OFS_LAST: rd_val = {15'h0000, pend, last};
      default: rd_hit = 1'b0;
    endcase
    bus_wval = 32'h00000000;
    wr_hit = 1'b1;
    case (aw_addr)
      ofd_pkg::OFS_BANK: bus_wval = {28'h0000000, bank};
      ofd_pkg::OFS_PTR0: bus_wval = {20'h00000, ptr[0]};
      ofd_pkg::OFS_PTR0 + 8'h04: bus_wval = {20'h00000, ptr[1]};
      ofd_pkg::OFS_PTR2: bus_wval = {20'h00000, ptr[2]};
      ofd_pkg::OFS_TBL_PTR: bus_wval = {11'h000, tbl_ptr};
      ofd_pkg::OFS_TBL_LATCH: bus_wval = {24'h000000, tbl_latch};
      ofd_pkg::OFS_FLAGS: bus_wval = {27'h0000000, flags};
      default: wr_hit = 1'b0;
    endcase
    for (int i = 0; i < 4; i++) begin
      if (w_strb[i]) begin
        bus_wval[i*8 +: 8] = w_data[i*8 +: 8];
      end
    end
  end

  // Next state; core updates are applied after bus writes so hardware wins a tie.
  always_comb begin
    bus_we = aw_full & w_full & ~bvalid;
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full = w_full;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid & ~i_bready;
    next_bresp = bresp;
    next_rvalid = rvalid & ~i_rready;
    next_rdata = rdata;
    next_rresp = rresp;
    if (i_awvalid & ~aw_full) begin
      next_aw_full = 1'b1;
      next_aw_addr = i_awaddr;
    end
    if (i_wvalid & ~w_full) begin
      next_w_full = 1'b1;
      next_w_data = i_wdata;
      next_w_strb = i_wstrb;
    end
    if (bus_we) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_hit ? ofd_pkg::RESP_OKAY : ofd_pkg::RESP_SLVERR;
    end
    if (i_arvalid & ~rvalid) begin
      next_rvalid = 1'b1;
      next_rdata = rd_val;
      next_rresp = rd_hit ? ofd_pkg::RESP_OKAY : ofd_pkg::RESP_SLVERR;
    end
    next_bank = bank;
    next_tbl_ptr = tbl_ptr;
    next_tbl_latch = tbl_latch;
    next_flags = flags;
    if (bus_we & (aw_addr == ofd_pkg::OFS_BANK)) next_bank = bus_wval[3:0];
    if (bus_we & (aw_addr == ofd_pkg::OFS_TBL_PTR)) next_tbl_ptr = bus_wval[20:0];
    if (bus_we & (aw_addr == ofd_pkg::OFS_TBL_LATCH)) next_tbl_latch = bus_wval[7:0];
    if (bus_we & (aw_addr == ofd_pkg::OFS_FLAGS)) next_flags = bus_wval[4:0];
    next_pend = pend;
    next_first = first;
    next_last = last;
    next_sh_acc = sh_acc;
    next_sh_flags = sh_flags;
    next_sh_bank = sh_bank;
    if (ex) begin
      next_last = i_instr;
      next_pend = (o_class == ofd_pkg::OFD_CL_FIRST);
      next_first = i_instr;
      next_flags = (flags & ~o_flag_mask) | (i_alu_flags & o_flag_mask); // [RL13]
      if (bank_lit_we) next_bank = i_instr[3:0];
      if (o_tbl_rd | o_tbl_wr) next_tbl_ptr = tbl_next; // [RL7]
      if (o_tbl_rd) next_tbl_latch = i_tbl_rdata; // [RL10]
      if (o_shadow_save) begin
        next_sh_acc = i_working_accumulator; // [RL9]
        next_sh_flags = flags; // [RL9]
        next_sh_bank = bank; // [RL9]
      end
      if (o_shadow_restore) begin
        next_flags = sh_flags; // [RL9]
        next_bank = sh_bank; // [RL9]
      end
    end
  end

  // Pointer registers: bus write, then a pointer load from the decoder on top.
  for (genvar g = 0; g < 3; g++) begin : g_ptr
    assign ptr_bus_we[g] = bus_we & (aw_addr == ofd_pkg::OFS_PTR0 + 8'(4 * g));
    assign next_ptr[g] = (ex & lfsr_we & (o_ptr_sel == 2'(g))) ? o_literal[11:0] :
                         ptr_bus_we[g] ? bus_wval[11:0] : ptr[g]; // [RL4]
  end

  // Registers only; every value is computed above.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bank <= ofd_pkg::RST_BANK;
      sh_bank <= ofd_pkg::RST_BANK;
      for (int i = 0; i < 3; i++) ptr[i] <= ofd_pkg::RST_PTR;
      tbl_ptr <= ofd_pkg::RST_TBL_PTR;
      tbl_latch <= ofd_pkg::RST_TBL_LATCH;
      sh_acc <= ofd_pkg::RST_TBL_LATCH;
      flags <= ofd_pkg::RST_FLAGS;
      sh_flags <= ofd_pkg::RST_FLAGS;
      pend <= 1'b0;
      first <= 16'h0000;
      last <= 16'h0000;
      aw_full <= 1'b0;
      aw_addr <= 8'h00;
      w_full <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= ofd_pkg::RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= ofd_pkg::RESP_OKAY;
    end else begin
      bank <= next_bank;
      sh_bank <= next_sh_bank;
      for (int i = 0; i < 3; i++) ptr[i] <= next_ptr[i];
      tbl_ptr <= next_tbl_ptr;
      tbl_latch <= next_tbl_latch;
      sh_acc <= next_sh_acc;
      flags <= next_flags;
      sh_flags <= next_sh_flags;
      pend <= next_pend;
      first <= next_first;
      last <= next_last;
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full <= next_w_full;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end
endmodule : ofd_decoder
`default_nettype wire

// >>> core/ofd_pkg.sv
package ofd_pkg;
  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] OFS_BANK = 8'h00;
  localparam logic [7:0] OFS_PTR0 = 8'h04;
  localparam logic [7:0] OFS_PTR2 = 8'h0C;
  localparam logic [7:0] OFS_TBL_PTR = 8'h10;
  localparam logic [7:0] OFS_TBL_LATCH = 8'h14;
  localparam logic [7:0] OFS_FLAGS = 8'h18;
  localparam logic [7:0] OFS_LAST = 8'h1C;
  // Reset values.
  localparam logic [3:0] RST_BANK = 4'h0;
  localparam logic [11:0] RST_PTR = 12'h000;
  localparam logic [20:0] RST_TBL_PTR = 21'h000000;
  localparam logic [7:0] RST_TBL_LATCH = 8'h00;
  localparam logic [4:0] RST_FLAGS = 5'h00;
  // Field positions inside an instruction word.
  localparam int POS_DEST = 9;
  localparam int POS_ACC = 8;
  localparam int POS_CALL_FAST = 8;
  localparam int POS_RET_FAST = 0;
  // First address of the upper part of the fixed access region.
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [3:0] SECOND_WORD_TAG = 4'hF;
  // Status flag masks, bit 0 carry, 1 half carry, 2 zero, 3 signed wrap, 4 negative.
  localparam logic [4:0] MASK_NONE = 5'h00;
  localparam logic [4:0] MASK_ALL = 5'h1F;
  localparam logic [4:0] MASK_ZN = 5'h14;
  localparam logic [4:0] MASK_CZN = 5'h15;
  localparam logic [4:0] MASK_Z = 5'h04;
  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    OFD_TBL_HOLD, OFD_TBL_POSTINC, OFD_TBL_POSTDEC, OFD_TBL_PREINC
  } ofd_tbl_mode_t;

  typedef enum logic [1:0] {OFD_LIT_NONE, OFD_LIT_8, OFD_LIT_12, OFD_LIT_20} ofd_lit_t;

  typedef enum logic [3:0] {
    OFD_CL_NOP, OFD_CL_FIRST, OFD_CL_BYTE, OFD_CL_BIT, OFD_CL_LIT, OFD_CL_MOVFF,
    OFD_CL_INDEXED, OFD_CL_BRANCH, OFD_CL_CTRL, OFD_CL_TABLE
  } ofd_class_t;
endpackage : ofd_pkg

// >>> core/ofd_program_table_pointer_unit.sv
`timescale 1ns/100ps
`default_nettype none
module ofd_tbl_ptr_unit (
  // Current pointer and update mode.
  input wire logic [20:0] i_ptr,
  input wire ofd_pkg::ofd_tbl_mode_t i_mode,
  // Address used for this access and pointer after it.
  output logic [20:0] o_addr,
  output logic [20:0] o_next
);
  // The pre-increment form uses the bumped value for the access itself.
  always_comb begin
    o_addr = i_ptr;
    o_next = i_ptr;
    case (i_mode)
      ofd_pkg::OFD_TBL_HOLD: o_next = i_ptr; // [RL7]
      ofd_pkg::OFD_TBL_POSTINC: o_next = i_ptr + 21'h000001; // [RL7]
      ofd_pkg::OFD_TBL_POSTDEC: o_next = i_ptr - 21'h000001; // [RL7]
      ofd_pkg::OFD_TBL_PREINC: begin
        o_next = i_ptr + 21'h000001; // [RL7]
        o_addr = i_ptr + 21'h000001;
      end
      default: o_next = i_ptr;
    endcase
  end
endmodule : ofd_tbl_ptr_unit
`default_nettype wire

// >>> test/ofd_decoder_sva.sv
`timescale 1ns/100ps
`default_nettype none
module ofd_decoder_sva (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Instruction side.
  input wire logic [15:0] i_instr,
  input wire logic i_instr_valid,
  input wire logic [4:0] i_alu_flags,
  input wire logic [7:0] i_working_accumulator,
  input wire logic [7:0] i_tbl_rdata,
  // Decoded fields and held state.
  input wire ofd_pkg::ofd_class_t o_class,
  input wire logic o_nop,
  input wire logic o_second_word,
  input wire logic [11:0] o_file_addr,
  input wire logic [2:0] o_bit_sel,
  input wire logic [7:0] o_bit_mask,
  input wire logic o_dest_file,
  input wire logic o_branch_rel,
  input wire logic [20:0] o_branch_disp,
  input wire logic [4:0] o_flag_mask,
  input wire logic [4:0] o_flags,
  input wire logic o_tbl_rd,
  input wire logic [7:0] o_tbl_wdata,
  input wire logic o_shadow_save,
  input wire logic o_shadow_restore,
  input wire logic [7:0] o_shadow_accumulator
);
  // All checks share the core clock and pause while reset is low.
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_arst_n);

  property p_bit_pick;
    o_class == ofd_pkg::OFD_CL_BIT |->
      o_bit_sel == i_instr[11:9] && o_bit_mask == (8'h01 << i_instr[11:9]);
  endproperty
  a_bit_pick: assert property (p_bit_pick) else $error("bit pick wrong");

  property p_dest;
    o_class == ofd_pkg::OFD_CL_BYTE && i_instr[15:12] inside {[4'h1:4'h5]} |->
      o_dest_file == i_instr[9];
  endproperty
  a_dest: assert property (p_dest) else $error("destination wrong");

  // Access region splits at 60h when the access bit is clear.
  property p_access;
    (o_class == ofd_pkg::OFD_CL_BYTE || o_class == ofd_pkg::OFD_CL_BIT) && !i_instr[8] |->
      o_file_addr == {(i_instr[7:0] < 8'h60) ? 4'h0 : 4'hF, i_instr[7:0]};
  endproperty
  a_access: assert property (p_access) else $error("access address wrong");

  // A fast return reloads the flags, so it is left out here.
  property p_flags;
    i_instr_valid && !o_shadow_restore |=> o_flags ==
      (($past(o_flags) & ~$past(o_flag_mask)) | ($past(i_alu_flags) & $past(o_flag_mask)));
  endproperty
  a_flags: assert property (p_flags) else $error("flag merge wrong");

  property p_latch;
    o_tbl_rd |-> i_instr_valid ##1 o_tbl_wdata == $past(i_tbl_rdata);
  endproperty
  a_latch: assert property (p_latch) else $error("table latch wrong");

  property p_save;
    o_shadow_save |-> i_instr_valid ##1 o_shadow_accumulator == $past(i_working_accumulator);
  endproperty
  a_save: assert property (p_save) else $error("shadow save wrong");

  property p_lone;
    i_instr[15:12] == 4'hF && !o_second_word |-> o_nop && o_class == ofd_pkg::OFD_CL_NOP;
  endproperty
  a_lone: assert property (p_lone) else $error("lone word not idle");

  property p_rel;
    i_instr[15:11] == 5'h1A && !o_second_word |->
      o_branch_rel && o_branch_disp[20] == i_instr[10];
  endproperty
  a_rel: assert property (p_rel) else $error("relative branch wrong");
endmodule : ofd_decoder_sva

bind ofd_decoder ofd_decoder_sva u_sva (.*);
`default_nettype wire

// >>> test/ofd_decoder_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module ofd_decoder_tb_top;
  // Stimulus, observed outputs and bookkeeping.
  logic i_core_clk = 1'h0;
  logic i_arst_n = 1'h0;
  logic [7:0] i_awaddr = 8'h00;
  logic [7:0] i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0] i_wstrb = 4'hF;
  logic i_awvalid = 1'h0;
  logic i_wvalid = 1'h0;
  logic i_bready = 1'h0;
  logic i_arvalid = 1'h0;
  logic i_rready = 1'h0;
  logic [15:0] i_instr = 16'h0000;
  logic i_instr_valid = 1'h0;
  logic [4:0] i_alu_flags = 5'h00;
  logic [7:0] i_working_accumulator = 8'h00;
  logic [7:0] i_tbl_rdata;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_nop, o_second_word;
  logic o_dest_file, o_branch_rel, o_tbl_rd, o_tbl_wr, o_shadow_save, o_shadow_restore;
  logic [1:0] o_bresp, o_rresp, o_ptr_sel;
  logic [31:0] o_rdata, r;
  logic [11:0] o_file_addr, o_src_addr, o_dst_addr, k;
  logic [2:0] o_bit_sel;
  logic [7:0] o_bit_mask, o_tbl_wdata, o_shadow_accumulator;
  logic [7:0] sh = 8'h00;
  logic [19:0] o_literal, o_branch_target;
  logic [20:0] o_branch_disp, o_tbl_addr, t, e;
  logic [4:0] o_flag_mask, o_flags;
  logic [4:0] ef = 5'h00;
  ofd_pkg::ofd_class_t o_class;
  ofd_pkg::ofd_lit_t o_lit_kind;
  ofd_pkg::ofd_tbl_mode_t o_tbl_mode;
  logic [15:0] ops [5] = '{16'h2400, 16'h1400, 16'h6E00, 16'h6A00, 16'h3400};
  logic [4:0] fm [5] = '{5'h1F, 5'h14, 5'h00, 5'h04, 5'h15};
  int seed = 32'h4270;
  int err_count = 0;
  int checked = 0;

  // Design and the program memory beside it.
  ofd_decoder dut (.*);
  ofd_progmem_model pmem (.i_addr(o_tbl_addr), .o_byte(i_tbl_rdata));

  // Free-running core clock.
  always #5 i_core_clk = ~i_core_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (err_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // One word per call; decode is combinational, so it is read mid-cycle.
  task automatic ex(input logic [15:0] w, input logic v);
    @(posedge i_core_clk);
    i_instr <= w;
    i_instr_valid <= v;
    i_alu_flags <= 5'($random(seed));
    i_working_accumulator <= 8'($random(seed));
    @(negedge i_core_clk);
  endtask : ex

  // Handshakes are judged at the falling edge, where inputs are settled.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] dt, input logic [1:0] er);
    logic pa, pw, ta, tw;
    pa = 1'h1;
    pw = 1'h1;
    @(posedge i_core_clk);
    i_awaddr <= a;
    i_wdata <= dt;
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    i_bready <= 1'h1;
    while (pa || pw) begin
      @(negedge i_core_clk);
      ta = pa && o_awready;
      tw = pw && o_wready;
      @(posedge i_core_clk);
      if (ta) i_awvalid <= 1'h0;
      if (tw) i_wvalid <= 1'h0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    @(negedge i_core_clk);
    while (!o_bvalid) @(negedge i_core_clk);
    chk(o_bresp, er);
    @(posedge i_core_clk);
    i_bready <= 1'h0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge i_core_clk);
    i_araddr <= a;
    i_arvalid <= 1'h1;
    i_rready <= 1'h1;
    @(negedge i_core_clk);
    while (!o_arready) @(negedge i_core_clk);
    @(posedge i_core_clk);
    i_arvalid <= 1'h0;
    @(negedge i_core_clk);
    while (!o_rvalid) @(negedge i_core_clk);
    chk(o_rdata, ed);
    chk(o_rresp, er);
    @(posedge i_core_clk);
    i_rready <= 1'h0;
  endtask : axi_rd

  function automatic logic [11:0] fa(input logic [3:0] b, input logic a, input logic [7:0] f);
    if (a) return {b, f};
    return {(f < 8'h60) ? 4'h0 : 4'hF, f};
  endfunction : fa

  function automatic logic [20:0] nxt(input logic [20:0] p, input logic [1:0] m);
    return (m == 2'h0) ? p : (m == 2'h2) ? p - 21'h1 : p + 21'h1;
  endfunction : nxt

  // The test sequence.
  initial begin
    repeat (6) @(posedge i_core_clk);
    i_arst_n <= 1'h1;
    r = 32'($random(seed));
    axi_wr(8'h00, r, 2'h0);
    axi_wr(8'h1C, 32'h0, 2'h2);
    axi_rd(8'h20, 32'h0, 2'h2);
    for (int i = 0; i < 8; i++) begin
      k[7:0] = (i < 2) ? 8'h5F + 8'(i) : 8'($random(seed));
      ex({6'h09, i[0], i[1], k[7:0]}, 1'h1);
      chk(o_file_addr, fa(r[3:0], i[1], k[7:0]));
      chk(o_dest_file, i[0]);
    end
    for (int i = 0; i < 5; i++) begin
      ex(ops[i], 1'h1);
      chk(o_flag_mask, fm[i]);
      ef = (ef & ~fm[i]) | (i_alu_flags & fm[i]);
    end
    for (int i = 0; i < 8; i++) begin
      ex({4'h8, i[2:0], 1'h0, 8'h10}, 1'h1);
      chk(o_bit_sel, i);
      chk(o_bit_mask, 32'h1 << i);
    end
    ex(16'h0000, 1'h0);
    axi_rd(8'h18, {27'h0, ef}, 2'h0);
    k = 12'($random(seed));
    ex({8'h0E, k[7:0]}, 1'h1);
    chk(o_literal, k[7:0]);
    chk(o_lit_kind, ofd_pkg::OFD_LIT_8);
    for (int p = 0; p < 3; p++) begin
      k = 12'($random(seed));
      ex({10'h3B8, p[1:0], k[11:8]}, 1'h1);
      ex({8'hF0, k[7:0]}, 1'h1);
      chk(o_ptr_sel, p);
      chk(o_literal, k);
      chk(o_lit_kind, ofd_pkg::OFD_LIT_12);
      ex(16'h0000, 1'h0);
      axi_rd(8'(4 * p + 4), k, 2'h0);
    end
    t = 21'($random(seed));
    ex({4'hC, t[11:0]}, 1'h1);
    chk(o_class, ofd_pkg::OFD_CL_FIRST);
    ex({4'hF, t[20:9]}, 1'h1);
    chk(o_second_word, 1'h1);
    chk(o_src_addr, t[11:0]);
    chk(o_dst_addr, t[20:9]);
    ex({4'hF, t[15:4]}, 1'h1);
    chk(o_nop, 1'h1);
    ex({9'h1D7, t[6:0]}, 1'h1);
    ex({4'hF, t[20:16], t[13:7]}, 1'h1);
    chk(o_src_addr, 12'(k + t[6:0]));
    chk(o_dst_addr, 12'(k + t[13:7]));
    for (int i = 0; i < 2; i++) begin
      r = 32'($random(seed));
      ex({5'h1A, i[0], r[9:0]}, 1'h1);
      chk(o_branch_disp[20], i[0]);
      ex({8'hEF, r[17:10]}, 1'h1);
      ex({4'hF, r[29:18]}, 1'h1);
      chk(o_branch_rel, 1'h0);
      chk(o_branch_target, r[29:10]);
      chk(o_lit_kind, ofd_pkg::OFD_LIT_20);
      ex({7'h76, i[0], r[7:0]}, 1'h1);
      ex({4'hF, r[19:8]}, 1'h1);
      chk(o_shadow_save, i[0]);
      sh = i[0] ? i_working_accumulator : sh;
      ex(16'h0012 | 16'(i), 1'h1);
      chk(o_shadow_restore, i[0]);
      chk(o_shadow_accumulator, sh);
    end
    ex(16'h0000, 1'h0);
    for (int m = 0; m < 4; m++) begin
      t = (m == 1) ? 21'h1FFFFF : 21'($random(seed));
      e = (m == 3) ? nxt(t, 2'h3) : t;
      axi_wr(8'h10, {11'h0, t}, 2'h0);
      ex(16'h0008 | 16'(m), 1'h1);
      chk(o_tbl_rd, 1'h1);
      chk(o_tbl_mode, m);
      chk(o_tbl_addr, e);
      ex(16'h0000, 1'h0);
      axi_rd(8'h10, {11'h0, nxt(t, 2'(m))}, 2'h0);
      axi_rd(8'h14, {24'h0, e[7:0] ^ e[15:8] ^ 8'h5A}, 2'h0);
    end
    ex(16'h000C, 1'h1);
    chk(o_tbl_wr, 1'h1);
    tally_and_finish();
  end

  // A hang ends the run with a counted mismatch.
  initial begin
    repeat (20000) @(posedge i_core_clk);
    err_count++;
    tally_and_finish();
  end
endmodule : ofd_decoder_tb_top
`default_nettype wire

// >>> test/ofd_progmem_model.sv
`timescale 1ns/100ps
`default_nettype none
module ofd_progmem_model (
  // Byte address from the table unit.
  input wire logic [20:0] i_addr,
  // Program memory byte, answered in the same cycle.
  output logic [7:0] o_byte
);
  // A scrambled pattern, so a wrong address shows as a wrong byte.
  assign o_byte = i_addr[7:0] ^ i_addr[15:8] ^ 8'h5A;
endmodule : ofd_progmem_model
`default_nettype wire
